// File: inc/sarseq_params.svh
// Offsets, field positions, reset values and timing of the converter sequencer
`ifndef SARSEQ_PARAMS_SVH
`define SARSEQ_PARAMS_SVH

`define SARSEQ_ADDR_DIR        16'hff22
`define SARSEQ_ADDR_CHAN       16'hff29
`define SARSEQ_ADDR_CFG        16'hff2f
`define SARSEQ_ADDR_RES_HIGH   16'hff09
`define SARSEQ_ADDR_RES_LOW    16'hff08
`define SARSEQ_ADDR_MODE       16'hff28

`define SARSEQ_MODE_RUN_BIT    7
`define SARSEQ_MODE_TIME_MSB   5
`define SARSEQ_MODE_TIME_LSB   1
`define SARSEQ_MODE_EN_BIT     0
`define SARSEQ_CHAN_MSB        2
`define SARSEQ_CFG_MSB         3

`define SARSEQ_DIR_RESET       8'hff
`define SARSEQ_RES_WORD_RESET  16'h0000
`define SARSEQ_RES_HIGH_RESET  8'h00
`define SARSEQ_SAR_FIRST       10'h200
`define SARSEQ_SAR_TOP         4'h9

`define SARSEQ_CLK_NS          10
`define SARSEQ_SAMPLE_NS       1000
`define SARSEQ_STEP_NS         200

`endif

// File: inc/sarseq_pkg.sv
// Types shared by the converter sequencer
package sarseq_pkg;
	typedef enum logic [2:0]
	{
		SARSEQ_IDLE    = 3'b001,
		SARSEQ_SAMPLE  = 3'b010,
		SARSEQ_COMPARE = 3'b100
	} sarseq_state_t;
endpackage : sarseq_pkg

// File: logic/sarseq_core.sv
// Successive-approximation converter sequencer with port pin configuration
// Notes on behaviour
// - Direction bit 0 turns pin output buffer on, 1 turns it off.
// - Reset loads direction register with all ones, every pin input.
// - Pin function follows analog config, direction and channel; analog output prohibited.
// - Mode bit 0 powers the comparator before any conversion.
// - Mode bit 7 starts conversion; rest proceeds in hardware.
// - Sample selected channel a fixed interval, then hold until conversion ends.
// - Approximation starts with bit 9 set, tap at half reference.
// - Bit 9 stays 1 if input at/above half tap, else cleared.
// - Bit 8 tried next at three or one quarter; kept when input at/above tap.
// - Continue to bit 0, then copy value into both result registers.
// - Completion interrupt raised together with the result transfer.
// - Conversions repeat back to back, each newly sampled, while run is 1.
// - Channel select write aborts conversion, restarts from sampling if running.
// - Reset clears result word to 0000 and high byte to 00.
// - Result word holds ten-bit value, high byte its upper eight bits.
// - Result stored left-justified: word equals approximation value times 64.
// - Single channel select mode: only the selected input is converted.
// - Channel code in bits 2 to 0; bits 3 to 7 written 0.
// - Clearing run stops conversion at once, previous result kept.
// - Mode, channel or config write at conversion end wins; no store, no interrupt.
`timescale 1ns/100ps
`include "sarseq_params.svh"

module sarseq_core
	import sarseq_pkg::*;
#(
	parameter int SAMPLE_CYCLES = (`SARSEQ_SAMPLE_NS + `SARSEQ_CLK_NS - 1) / `SARSEQ_CLK_NS,
	parameter int STEP_CYCLES   = (`SARSEQ_STEP_NS + `SARSEQ_CLK_NS - 1) / `SARSEQ_CLK_NS,
	parameter int CNT_W         = 16
)
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        cmp_above,
	output logic             comparator_enable,
	output logic      [2:0]  channel_sel,
	output logic             sh_sample,
	output logic             sh_hold,
	output logic      [9:0]  tap_code,
	output logic      [7:0]  analog_connect,
	output logic      [7:0]  pin_out_en,
	output logic      [15:0] result_word,
	output logic      [7:0]  result_high_byte,
	output logic             conversion_done_irq
);

	generate
		if (SAMPLE_CYCLES < 1 || STEP_CYCLES < 1 || CNT_W < 2)
			$error("sarseq_core: counts must be at least one cycle");
		if (SAMPLE_CYCLES >= (1 << CNT_W) || STEP_CYCLES >= (1 << CNT_W))
			$error("sarseq_core: counter too narrow for timing counts");
	endgenerate

	localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] STEP_LOAD   = CNT_W'(STEP_CYCLES - 1);

	logic [7:0]       port_direction_reg;
	logic             conversion_run;
	logic [4:0]       conv_time_sel;
	logic [2:0]       channel_select_reg;
	logic [3:0]       pin_analog_config_reg;
	sarseq_state_t    state;
	sarseq_state_t    next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [9:0]       sar;
	logic [3:0]       bit_idx;

	// Register decode
	wire wr_dir  = reg_wr && (reg_addr == `SARSEQ_ADDR_DIR);
	wire wr_mode = reg_wr && (reg_addr == `SARSEQ_ADDR_MODE);
	wire wr_chan = reg_wr && (reg_addr == `SARSEQ_ADDR_CHAN);
	wire wr_cfg  = reg_wr && (reg_addr == `SARSEQ_ADDR_CFG);
	wire mode_run = reg_wdata[`SARSEQ_MODE_RUN_BIT];
	wire mode_en  = reg_wdata[`SARSEQ_MODE_EN_BIT];

	// Run is dropped with enable, otherwise the sequencer would restart unpowered
	wire stop_req = wr_mode && !(mode_run && mode_en);
	wire collide  = wr_mode || wr_chan || wr_cfg;

	wire in_idle    = (state == SARSEQ_IDLE);
	wire in_sample  = (state == SARSEQ_SAMPLE);
	wire in_compare = (state == SARSEQ_COMPARE);
	wire cnt_zero   = (cnt == '0);
	wire step_end   = in_compare && cnt_zero;
	wire last_step  = step_end && (bit_idx == 4'h0);
	wire do_store   = last_step && !collide;

	// Trial bit decided, next lower bit tentatively set
	wire [9:0] bit_mask = 10'h001 << bit_idx;
	wire [9:0] next_sar = (cmp_above ? sar : (sar & ~bit_mask)) | (bit_mask >> 1);

	wire [7:0] chan_onehot = 8'h01 << channel_select_reg;
	wire [7:0] analog_mask = 8'hff << pin_analog_config_reg;

	wire [7:0] mode_read = {conversion_run, 1'b0, conv_time_sel, comparator_enable};
	wire [7:0] read_mux =
		(reg_addr == `SARSEQ_ADDR_DIR)      ? port_direction_reg :
		(reg_addr == `SARSEQ_ADDR_MODE)     ? mode_read :
		(reg_addr == `SARSEQ_ADDR_CHAN)     ? {5'h00, channel_select_reg} :
		(reg_addr == `SARSEQ_ADDR_CFG)      ? {4'h0, pin_analog_config_reg} :
		(reg_addr == `SARSEQ_ADDR_RES_HIGH) ? result_high_byte :
		(reg_addr == `SARSEQ_ADDR_RES_LOW)  ? result_word[7:0] :
		8'h00;

	// Pin control; analog pins never drive, which also covers the prohibited combination
	assign pin_out_en     = ~port_direction_reg & ~analog_mask;
	assign analog_connect = analog_mask & port_direction_reg & chan_onehot
		& {8{in_sample}};
	assign channel_sel    = channel_select_reg;
	assign sh_sample      = in_sample;
	assign sh_hold        = in_compare;
	assign tap_code       = sar;

	always_comb
	begin
		next_state = state;
		case (state)
			SARSEQ_IDLE:
			begin
				if (conversion_run && !stop_req)
					next_state = SARSEQ_SAMPLE;
			end
			SARSEQ_SAMPLE:
			begin
				if (stop_req)
					next_state = SARSEQ_IDLE;
				else if (cnt_zero && !wr_chan)
					next_state = SARSEQ_COMPARE;
			end
			SARSEQ_COMPARE:
			begin
				if (stop_req)
					next_state = SARSEQ_IDLE;
				else if (wr_chan || last_step)
					next_state = SARSEQ_SAMPLE;
			end
			default:
				next_state = SARSEQ_IDLE;
		endcase
	end

	wire reload = (next_state != state) || wr_chan || step_end;

	always_comb
	begin
		if (next_state == SARSEQ_IDLE)
			next_cnt = '0;
		else if (reload)
			next_cnt = (next_state == SARSEQ_SAMPLE) ? SAMPLE_LOAD : STEP_LOAD;
		else
			next_cnt = cnt - CNT_W'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			port_direction_reg    <= `SARSEQ_DIR_RESET;
			conversion_run        <= 1'b0;
			comparator_enable     <= 1'b0;
			conv_time_sel         <= 5'h00;
			channel_select_reg    <= 3'h0;
			pin_analog_config_reg <= 4'h0;
		end
		else
		begin
			if (wr_dir)
				port_direction_reg <= reg_wdata;
			if (wr_mode)
			begin
				conversion_run    <= mode_run && mode_en;
				comparator_enable <= mode_en;
				conv_time_sel     <= reg_wdata[`SARSEQ_MODE_TIME_MSB:`SARSEQ_MODE_TIME_LSB];
			end
			if (wr_chan)
				channel_select_reg <= reg_wdata[`SARSEQ_CHAN_MSB:0];
			if (wr_cfg)
				pin_analog_config_reg <= reg_wdata[`SARSEQ_CFG_MSB:0];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state   <= SARSEQ_IDLE;
			cnt     <= '0;
			sar     <= 10'h000;
			bit_idx <= 4'h0;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
			// Leaving compare clears first, so an aborted step never leaves a tap outside hold
			if (next_state == SARSEQ_COMPARE && !in_compare)
			begin
				sar     <= `SARSEQ_SAR_FIRST;
				bit_idx <= `SARSEQ_SAR_TOP;
			end
			else if (next_state != SARSEQ_COMPARE)
			begin
				sar     <= 10'h000;
				bit_idx <= 4'h0;
			end
			else if (step_end)
			begin
				sar     <= next_sar;
				bit_idx <= bit_idx - 4'h1;
			end
		end
	end

	// Results move only here, so a read never sees a partial value
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			result_word         <= `SARSEQ_RES_WORD_RESET;
			result_high_byte    <= `SARSEQ_RES_HIGH_RESET;
			conversion_done_irq <= 1'b0;
		end
		else
		begin
			conversion_done_irq <= do_store;
			if (do_store)
			begin
				result_word      <= {next_sar, 6'h00};
				result_high_byte <= next_sar[9:2];
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= read_mux;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_outbuf_follow_dir: assert property (wr_dir |=> pin_out_en == (~$past(reg_wdata) & ~analog_mask))
		else $error("output enable does not follow direction write");
	a_start_to_sample: assert property (in_idle && wr_mode && mode_run && mode_en |=> ##1 sh_sample)
		else $error("run write did not start sampling");
	a_first_half_tap: assert property ($rose(sh_hold) |-> $past(sh_sample) && tap_code == 10'h200)
		else $error("first trial not at half reference");
	a_second_tap: assert property (step_end && bit_idx == 4'h9 && !collide
		|=> tap_code == {$past(cmp_above), 1'b1, 8'h00})
		else $error("second trial tap wrong");
	a_store_value: assert property (do_store
		|=> conversion_done_irq && result_word[15:6] == $past(next_sar))
		else $error("result not transferred with interrupt");
	a_left_justify: assert property (conversion_done_irq
		|-> result_word[5:0] == 6'h00 && result_high_byte == result_word[15:8])
		else $error("result layout wrong");
	a_result_hold: assert property (!conversion_done_irq
		|-> $stable(result_word) && $stable(result_high_byte))
		else $error("result changed outside transfer");
	a_repeat_sample: assert property (conversion_done_irq && conversion_run |-> sh_sample)
		else $error("next conversion did not start");
	a_chan_restart: assert property (wr_chan && !in_idle && !stop_req |=> sh_sample && cnt == SAMPLE_LOAD)
		else $error("channel write did not restart sampling");
	a_run_stop: assert property (stop_req |=> in_idle && !sh_hold && !sh_sample)
		else $error("stop did not idle the sequencer");
	a_collide_drop: assert property (last_step && collide |=> !conversion_done_irq)
		else $error("colliding write still stored result");
	a_single_channel: assert property ($onehot0(analog_connect))
		else $error("more than one input connected");

	// Invariants that hold whatever software does
	a_tap_outside_hold: assert property (!sh_hold |-> tap_code == 10'h000)
		else $error("tap not cleared outside hold");
	a_high_byte_match: assert property (result_high_byte == result_word[15:8])
		else $error("high byte differs from result word");
	a_low_bits_zero: assert property (result_word[5:0] == 6'h00)
		else $error("result word not left-justified");
	a_stop_keeps_result: assert property (stop_req |=> $stable(result_word) && !conversion_done_irq)
		else $error("stop disturbed the result");
	a_convert_powered: assert property (sh_sample || sh_hold |-> comparator_enable)
		else $error("conversion running with comparator off");
	a_irq_one_cycle: assert property (conversion_done_irq |=> !conversion_done_irq)
		else $error("completion pulse longer than one cycle");
	a_analog_no_drive: assert property ((pin_out_en & analog_mask) == 8'h00)
		else $error("analog pin drives its output");
	a_dir_hold: assert property (!wr_dir |=> $stable(port_direction_reg))
		else $error("direction changed without a write");

endmodule : sarseq_core

// File: testbench/sarseq_cmp_model.sv
// Behavioural comparator and sample-and-hold at the far side of the sequencer
`timescale 1ns/100ps

module sarseq_cmp_model
(
	input  wire logic             core_clk,
	input  wire logic             sh_sample,
	input  wire logic             sh_hold,
	input  wire logic [7:0]       analog_connect,
	input  wire logic [2:0]       channel_sel,
	input  wire logic [9:0]       tap_code,
	input  wire logic [7:0][9:0]  vin,
	output logic                  cmp_above
);
	logic [9:0] held = 10'h155;
	logic       toggle = 1'b0;

	// Only a switched-on pin reaches the capacitor; a stale level shows otherwise
	always @(posedge core_clk)
	begin
		if (sh_sample && analog_connect[channel_sel])
			held <= vin[channel_sel];
		toggle <= ~toggle;
	end

	// Outside hold the comparator output is meaningless, so it wanders
	assign cmp_above = sh_hold ? (held >= tap_code) : toggle;
endmodule : sarseq_cmp_model

// File: testbench/tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "sarseq_params.svh"

module tb_top;
	logic             core_clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic [15:0]      reg_addr = 16'h0000;
	logic             reg_wr = 1'b0;
	logic [7:0]       reg_wdata = 8'h00;
	logic             reg_rd = 1'b0;
	logic [7:0]       reg_rdata;
	logic             cmp_above;
	logic             comparator_enable;
	logic [2:0]       channel_sel;
	logic             sh_sample;
	logic             sh_hold;
	logic [9:0]       tap_code;
	logic [7:0]       analog_connect;
	logic [7:0]       pin_out_en;
	logic [15:0]      result_word;
	logic [7:0]       result_high_byte;
	logic             conversion_done_irq;
	logic [7:0][9:0]  vin = '0;
	int               errors = 0;
	int               tests_run = 0;
	localparam int    SAMPLE_N = 3;
	localparam int    STEP_N   = 2;

	always #5 core_clk = ~core_clk;

	sarseq_core #(.SAMPLE_CYCLES(SAMPLE_N), .STEP_CYCLES(STEP_N)) sarseq_core_inst (.core_clk(core_clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmp_above(cmp_above), .comparator_enable(comparator_enable), .channel_sel(channel_sel),
		.sh_sample(sh_sample), .sh_hold(sh_hold), .tap_code(tap_code), .analog_connect(analog_connect),
		.pin_out_en(pin_out_en), .result_word(result_word), .result_high_byte(result_high_byte),
		.conversion_done_irq(conversion_done_irq));

	sarseq_cmp_model sarseq_cmp_model_inst (.core_clk(core_clk), .sh_sample(sh_sample), .sh_hold(sh_hold),
		.analog_connect(analog_connect), .channel_sel(channel_sel), .tap_code(tap_code), .vin(vin),
		.cmp_above(cmp_above));

	function automatic logic [15:0] exp_word(input logic [9:0] v);
		return {v, 6'h00};
	endfunction : exp_word

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Called at a falling edge; strobes last one rising edge, then one idle edge before the next call
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		@(negedge core_clk);
	endtask : wr

	task automatic rd_check(input string what, input logic [15:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		check(what, {8'h00, exp}, {8'h00, reg_rdata});
		@(negedge core_clk);
	endtask : rd_check

	task automatic wait_irq(input int lim, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < lim && !seen; i++)
		begin
			@(negedge core_clk);
			seen = (conversion_done_irq === 1'b1);
		end
	endtask : wait_irq

	task automatic end_of_test;
		$display("Checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	initial
	begin
		#50000;
		errors++;
		end_of_test();
	end

	initial
	begin
		logic [7:0] d;
		logic [2:0] ch;
		logic       seen;
		logic [9:0] v;
		void'($urandom(19));
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		sys_rst = 1'b0;
		rd_check("direction", `SARSEQ_ADDR_DIR, 8'hff);
		rd_check("word low", `SARSEQ_ADDR_RES_LOW, 8'h00);
		rd_check("high byte", `SARSEQ_ADDR_RES_HIGH, 8'h00);
		rd_check("unmapped", 16'hff00, 8'h00);
		check("pin_out_en", 16'h0000, {8'h00, pin_out_en});
		$display("test reset done");
		wr(`SARSEQ_ADDR_CFG, 8'h08);
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($urandom);
			wr(`SARSEQ_ADDR_DIR, d);
			check("pin_out_en", {8'h00, ~d}, {8'h00, pin_out_en});
		end
		wr(`SARSEQ_ADDR_CFG, 8'h00);
		check("pin_out_en analog", 16'h0000, {8'h00, pin_out_en});
		wr(`SARSEQ_ADDR_DIR, 8'hff);
		$display("test pins done");
		d = {2'b00, 5'($urandom), 1'b1};
		wr(`SARSEQ_ADDR_MODE, d);
		check("comparator_enable", 16'h0001, {15'h0000, comparator_enable});
		rd_check("mode time", `SARSEQ_ADDR_MODE, d);
		repeat (100) @(negedge core_clk);
		for (int k = 0; k < 6; k++)
		begin
			ch = 3'($urandom);
			vin[ch] = (k == 0) ? 10'h000 : (k == 1) ? 10'h3ff : (k == 2) ? 10'h200 : 10'($urandom);
			wr(`SARSEQ_ADDR_CHAN, {5'h00, ch});
			if (k == 0)
				wr(`SARSEQ_ADDR_MODE, 8'h81);
			wait_irq(60, seen);
			check("irq", 16'h0001, {15'h0000, seen});
			check("result_word", exp_word(vin[ch]), result_word);
			check("result_high_byte", {8'h00, vin[ch][9:2]}, {8'h00, result_high_byte});
		end
		vin[ch] = 10'($urandom);
		wait_irq(60, seen);
		check("repeat irq", 16'h0001, {15'h0000, seen});
		check("repeat word", exp_word(vin[ch]), result_word);
		rd_check("high read", `SARSEQ_ADDR_RES_HIGH, vin[ch][9:2]);
		$display("test conversions done");
		wait_irq(60, seen);
		v = vin[ch];
		vin[ch] = ~v;
		repeat (SAMPLE_N + 10 * STEP_N - 1) @(negedge core_clk);
		reg_addr = `SARSEQ_ADDR_CFG;
		reg_wdata = 8'h00;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		check("collide irq", 16'h0000, {15'h0000, conversion_done_irq});
		check("collide word", exp_word(v), result_word);
		@(negedge core_clk);
		wait_irq(60, seen);
		check("restart irq", 16'h0001, {15'h0000, seen});
		check("restart word", exp_word(~v), result_word);
		$display("test collision done");
		repeat (5) @(negedge core_clk);
		wr(`SARSEQ_ADDR_MODE, 8'h01);
		wait_irq(60, seen);
		check("stopped irq", 16'h0000, {15'h0000, seen});
		check("kept word", exp_word(vin[ch]), result_word);
		check("stopped hold", 16'h0000, {15'h0000, sh_hold});
		$display("test stop done");
		wr(`SARSEQ_ADDR_MODE, 8'h81);
		repeat (10) @(negedge core_clk);
		wr(`SARSEQ_ADDR_MODE, 8'h00);
		check("disabled state", 16'h0000, {13'h0000, sh_sample, sh_hold, comparator_enable});
		rd_check("mode", `SARSEQ_ADDR_MODE, 8'h00);
		check("word after abort", exp_word(vin[ch]), result_word);
		$display("test disable done");
		end_of_test();
	end
endmodule : tb_top
